/* verilog/fdm_consts.svh */
`ifndef FDM_CONSTS_SVH
`define FDM_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FDM_OFF_STATUS  8'h00
`define FDM_OFF_COMM    8'h04
`define FDM_OFF_ISTAT   8'h08
`define FDM_OFF_IMASK   8'h0C
`define FDM_RF_PAGE     2'h1
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FDM_FLAG_LSB    2
`define FDM_EN_LSB      7
`define FDM_CAUSE_LSB   12
`define FDM_DN_BIT      18
`define FDM_PR_BIT      19
`define FDM_STATUS_RST  32'h0000_0000
`define FDM_STATUS_WMSK 32'h000F_FFFF
`define FDM_EV_DONE     0
`define FDM_EV_TRAP     1
`define FDM_EV_UNDEF    2
// ----------------------------------------------------------------
// Values, exponent offsets and opcodes
// ----------------------------------------------------------------
`define FDM_ZERO_SP     32'h0000_0000
`define FDM_ONE_SP      32'h3F80_0000
`define FDM_QNAN_SP     32'h7FBF_FFFF
`define FDM_INF_MAG     31'h7F80_0000
`define FDM_BIAS_SP     11'h07F
`define FDM_BIAS_DP     11'h3FF
`define FDM_ALIGN_TOP   11'h01D
`define FDM_EXP_FLOOR   11'h400
`define FDM_OP_GRP      4'hF
`define FDM_OP_MAC      4'hE
`define FDM_OP_DOT      8'hED
`define FDM_OP_LZ       8'h8D
`define FDM_OP_LO       8'h9D
`define FDM_OP_MOV      8'h1D
`define FDM_OP_CVT      8'h2D
`define FDM_RESP_OK     2'h0
`define FDM_RESP_ERR    2'h2
`endif

/* verilog/fdm_pkg.sv */
package fdm_pkg;
  // Instruction handed over by the issue logic.
  typedef struct packed {
    logic        valid;
    logic [15:0] opcode;
  } fdm_issue_s;
  // Exception cause bits, error down to inexact.
  typedef struct packed {
    logic e;
    logic v;
    logic z;
    logic o;
    logic u;
    logic i;
  } fdm_cause_s;
  typedef enum logic {
    fdm_idle = 1'h0,
    fdm_cvt2 = 1'h1
  } fdm_state_e;
endpackage

/* verilog/fdm_unit.sv */
`timescale 1ns/1ps
`include "fdm_consts.svh"
// Contract
// - Inner product, precision clear: sum of four products into last group reg.
// - Vector operand is the group of four registers at 0, 4, 8 or 12.
// - Inner product may differ from separate multiply and add results.
// - Products to 28 bits, aligned with rounding to 30, added, normalized.
// - Any signalling NaN input to inner product raises invalid.
// - Zero times infinity in any pair raises invalid.
// - Otherwise any quiet NaN input gives a quiet NaN result.
// - Infinite products of mixed sign raise invalid, else signed infinity.
// - Overflow, underflow or inexact enable traps every dot and mac with precision clear.
// - Exceptions go to cause and, all but error, to flag fields; invalid, denormal or trap leaves destination unchanged.
// - Zero load, precision clear, writes 0x00000000 in one state, no exception.
// - One load, precision clear, writes 0x3F800000 in one state, no exception.
// - Move copies the register into the communication register unchanged.
// - Precision clear: signed integer converted to single, one state.
// - Precision set: integer converted to double pair over two states.
// - Single convert flags inexact on loss; double never; enable traps.
// - Mac, precision clear: register 0 times source plus destination into destination.
// - Denormal flush set treats denormal operands as zero.
module fdm_unit (
  // Clock and reset.
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  // Instruction issue.
  input  wire fdm_pkg::fdm_issue_s issue_i,
  output logic                    issue_ready_o,
  output logic                    done_o,
  output logic                    trap_o,
  output logic                    undef_o,
  // AXI4-Lite slave.
  input  wire logic               axi_awvalid_i,
  input  wire logic [7:0]         axi_awaddr_i,
  output logic                    axi_awready_o,
  input  wire logic               axi_wvalid_i,
  input  wire logic [31:0]        axi_wdata_i,
  input  wire logic [3:0]         axi_wstrb_i,
  output logic                    axi_wready_o,
  output logic                    axi_bvalid_o,
  output logic [1:0]              axi_bresp_o,
  input  wire logic               axi_bready_i,
  input  wire logic               axi_arvalid_i,
  input  wire logic [7:0]         axi_araddr_i,
  output logic                    axi_arready_o,
  output logic                    axi_rvalid_o,
  output logic [31:0]             axi_rdata_o,
  output logic [1:0]              axi_rresp_o,
  input  wire logic               axi_rready_i,
  // Interrupt.
  output logic                    irq_o
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] lead1(input logic [31:0] x);
    lead1 = '0;
    for (int k = 0; k < 32; k++) begin
      if (x[k]) lead1 = k[4:0];
    end
  endfunction
  // Normalize a magnitude whose bit l weighs base+l; returns {o,u,i,value}.
  function automatic logic [34:0] pack_sp(input logic s,
      input logic [31:0] mag, input logic signed [10:0] base);
    logic [4:0] l;
    logic [31:0] nrm;
    logic [24:0] rnd;
    logic signed [10:0] ex;
    l = lead1(mag);
    nrm = mag << (5'h1F - l);
    rnd = {2'h1, nrm[30:8]} + {24'h00_0000, nrm[7]};
    ex = base + $signed({6'h00, l}) + $signed({10'h000, rnd[24]});
    if (mag == '0) pack_sp = '0;
    else if (ex >= 11'sh0FF) pack_sp = {3'h5, s, 8'hFF, 23'h00_0000};
    else if (ex <= 11'sh000) pack_sp = {3'h3, s, 31'h0000_0000};
    else pack_sp = {2'h0, |nrm[7:0], s, ex[7:0],
                    rnd[24] ? rnd[23:1] : rnd[22:0]};
  endfunction
  function automatic logic [31:0] wmerge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    wmerge = o;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) wmerge[8*k +: 8] = d[8*k +: 8];
    end
  endfunction
  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  fdm_pkg::fdm_state_e state_reg, state_next;
  fdm_pkg::fdm_cause_s cause_n, ar_cause;
  logic [31:0] rf [16];
  logic [31:0] status_reg, comm_reg, istat_reg, imask_reg, lo_reg;
  logic [3:0]  lo_idx_reg;
  logic        ready_reg, done_reg, trap_reg, undef_reg, irq_reg;
  logic [15:0] op;
  logic        take, grp, op_dot, op_mac, op_lz, op_lo, op_mov, op_cvt;
  logic        pr, dn, en_i, en_oui;
  logic [4:0]  en;
  logic [3:0]  n4, ex_wa;
  logic [1:0]  vn, vm;
  logic [31:0] src_val, ex_old;

  // Field extraction and opcode match.
  assign op     = issue_i.opcode;
  assign take   = issue_i.valid & ready_reg;
  assign grp    = op[15:12] == `FDM_OP_GRP;
  assign op_dot = grp && op[7:0] == `FDM_OP_DOT;
  assign op_mac = grp && op[3:0] == `FDM_OP_MAC;
  assign op_lz  = grp && op[7:0] == `FDM_OP_LZ;
  assign op_lo  = grp && op[7:0] == `FDM_OP_LO;
  assign op_mov = grp && op[7:0] == `FDM_OP_MOV;
  assign op_cvt = grp && op[7:0] == `FDM_OP_CVT;
  assign n4     = op[11:8];
  assign vn     = op[11:10];
  assign vm     = op[9:8];
  assign pr     = status_reg[`FDM_PR_BIT];
  assign dn     = status_reg[`FDM_DN_BIT];
  assign en     = status_reg[`FDM_EN_LSB +: 5];
  assign en_i   = en[0];
  assign en_oui = |en[2:0];
  assign ex_wa  = op_dot ? {vn, 2'h3} : n4;
  assign src_val = rf[n4];
  assign ex_old  = rf[ex_wa];

  // ----------------------------------------------------------------
  // Product terms: dot uses four pairs, mac uses r0*rm and rn*1.0
  // ----------------------------------------------------------------
  logic [3:0]  t_snan, t_qnan, t_den, t_zinf, t_inf, t_zero, t_sgn;
  logic [3:0]  t_lost, t_al;
  logic [27:0] t_m [4];
  logic [30:0] t_v [4];
  logic signed [10:0] t_e [4];
  logic signed [10:0] emax;
  for (genvar k = 0; k < 4; k++) begin : g_term
    localparam logic [1:0] KI = 2'(k);
    logic [31:0] a, b;
    logic        az, bz, ai, bi, ad, bd;
    logic [47:0] p;
    logic [10:0] d;
    logic [30:0] x, sh;
    // Operand select and classification; flush per the mode bit.
    assign a = op_dot ? rf[{vn, KI}] : (k == 0) ? rf[0]
             : (k == 1) ? rf[n4] : '0;
    assign b = op_dot ? rf[{vm, KI}] : (k == 0) ? rf[op[7:4]]
             : (k == 1) ? `FDM_ONE_SP : '0;
    assign az = a[30:23] == '0 && (dn || a[22:0] == '0);
    assign bz = b[30:23] == '0 && (dn || b[22:0] == '0);
    assign ad = a[30:23] == '0 && !dn && a[22:0] != '0;
    assign bd = b[30:23] == '0 && !dn && b[22:0] != '0;
    assign ai = a[30:0] == `FDM_INF_MAG;
    assign bi = b[30:0] == `FDM_INF_MAG;
    assign t_snan[k] = (&a[30:22]) | (&b[30:22]);
    assign t_qnan[k] = (&a[30:23] && !a[22] && a[21:0] != '0)
                     | (&b[30:23] && !b[22] && b[21:0] != '0);
    assign t_den[k]  = ad | bd;
    assign t_zinf[k] = (az & bi) | (ai & bz);
    assign t_inf[k]  = ai | bi;
    assign t_zero[k] = az | bz;
    assign t_sgn[k]  = a[31] ^ b[31];
    // Product kept to 28 bits; the rest only feeds inexact.
    assign p = {1'h1, a[22:0]} * {1'h1, b[22:0]};
    assign t_m[k] = p[47] ? p[47:20] : p[46:19];
    assign t_lost[k] = p[47] ? |p[19:0] : |p[18:0];
    assign t_e[k] = $signed({3'h0, a[30:23]}) + $signed({3'h0, b[30:23]})
                  - $signed(`FDM_BIAS_SP) + $signed({10'h000, p[47]});
    // Align to the largest exponent, rounding to 30 bits.
    assign d  = 11'(emax - t_e[k]);
    assign x  = {t_m[k], 3'h0};
    assign sh = (d > 11'h01E) ? '0 : x >> d;
    assign t_v[k] = t_zero[k] ? '0 : {1'h0, sh[30:1]} + {30'h0, sh[0]};
    assign t_al[k] = !t_zero[k] && ((sh << d) != x);
  end

  // Largest exponent among the live products.
  always_comb begin
    emax = $signed(`FDM_EXP_FLOOR);
    for (int k = 0; k < 4; k++) begin
      if (!t_zero[k] && t_e[k] > emax) emax = t_e[k];
    end
  end

  // Signed sum of aligned terms; accuracy traded for one pass.
  logic signed [33:0] sum;
  logic [31:0] mag;
  logic [34:0] dot_pk, cvt_pk;
  always_comb begin
    sum = '0;
    for (int k = 0; k < 4; k++) begin
      sum = t_sgn[k] ? sum - $signed({3'h0, t_v[k]})
                     : sum + $signed({3'h0, t_v[k]});
    end
  end
  assign mag    = sum[33] ? 32'(-sum) : sum[31:0];
  assign dot_pk = pack_sp(sum[33], mag,
                          emax - $signed(`FDM_ALIGN_TOP));

  // Special cases in priority order.
  logic ar_wr, pinf, ninf;
  logic [31:0] ar_res;
  assign pinf = |(t_inf & ~t_sgn);
  assign ninf = |(t_inf & t_sgn);
  always_comb begin
    ar_cause = '0;
    ar_res   = dot_pk[31:0];
    ar_wr    = 1'h1;
    if (|t_snan || |t_zinf) begin
      ar_cause.v = 1'h1;
      ar_wr      = 1'h0;
    end else if (|t_qnan) begin
      ar_res = `FDM_QNAN_SP;
    end else if (|t_den) begin
      ar_cause.e = 1'h1;
      ar_wr      = 1'h0;
    end else if (|t_inf) begin
      ar_cause.v = pinf & ninf;
      ar_wr      = !(pinf & ninf);
      ar_res     = {ninf, `FDM_INF_MAG};
    end else begin
      {ar_cause.o, ar_cause.u} = dot_pk[34:33];
      ar_cause.i = dot_pk[32] | |t_lost | |t_al;
    end
  end

  // ----------------------------------------------------------------
  // Integer conversion
  // ----------------------------------------------------------------
  logic [31:0] cmag, cnrm, dhi, dlo;
  logic [4:0]  cl;
  logic [10:0] dexp;
  assign cmag   = comm_reg[31] ? 32'(-comm_reg) : comm_reg;
  assign cvt_pk = pack_sp(comm_reg[31], cmag, $signed(`FDM_BIAS_SP));
  assign cl     = lead1(cmag);
  assign cnrm   = cmag << (5'h1F - cl);
  assign dexp   = `FDM_BIAS_DP + {6'h00, cl};
  assign dhi    = (cmag == '0) ? '0 : {comm_reg[31], dexp, cnrm[30:11]};
  assign dlo    = {cnrm[10:0], 21'h00_0000};

  // ----------------------------------------------------------------
  // Execution: one state per op, double convert takes a second
  // ----------------------------------------------------------------
  logic        core_we, cause_we, comm_we, done_n, trap_n, undef_n;
  logic [3:0]  core_wa;
  logic [31:0] core_wd;
  always_comb begin
    state_next = state_reg;
    core_we  = 1'h0;
    core_wa  = ex_wa;
    core_wd  = ar_res;
    cause_we = 1'h0;
    cause_n  = '0;
    comm_we  = 1'h0;
    done_n   = 1'h0;
    trap_n   = 1'h0;
    undef_n  = 1'h0;
    unique case (state_reg)
      fdm_pkg::fdm_idle: begin
        if (take && (op_dot || op_mac)) begin
          if (pr) begin
            undef_n = 1'h1;
          end else begin
            done_n   = 1'h1;
            cause_we = 1'h1;
            cause_n  = ar_cause;
            trap_n   = ar_cause.e | |(ar_cause[4:0] & en) | en_oui;
            core_we  = ar_wr & !trap_n;
          end
        end else if (take && (op_lz || op_lo)) begin
          undef_n = pr;
          done_n  = !pr;
          core_we = !pr;
          core_wa = n4;
          core_wd = op_lz ? `FDM_ZERO_SP : `FDM_ONE_SP;
        end else if (take && op_cvt) begin
          cause_we = 1'h1;
          cause_n.i = !pr & cvt_pk[32];
          trap_n   = en_i | (!pr & cvt_pk[32] & en_i);
          core_we  = !trap_n;
          core_wa  = pr ? {n4[3:1], 1'h0} : n4;
          core_wd  = pr ? dhi : cvt_pk[31:0];
          done_n   = !pr | trap_n;
          if (pr && !trap_n) state_next = fdm_pkg::fdm_cvt2;
        end else if (take) begin
          comm_we = op_mov;
          done_n  = 1'h1;
        end
      end
      fdm_pkg::fdm_cvt2: begin
        core_we    = 1'h1;
        core_wa    = lo_idx_reg;
        core_wd    = lo_reg;
        done_n     = 1'h1;
        state_next = fdm_pkg::fdm_idle;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic       aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg;
  logic       arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg, rd_data;
  logic [3:0] w_strb_reg;
  logic       aw_take, w_take, ar_take, wr_fire, aw_full_next, w_full_next;
  logic       rvalid_next, wr_ok, rd_ok, rd_istat;
  logic       wr_stat, wr_comm, wr_mask, wr_rf;
  // Address decode for both directions.
  assign aw_take = axi_awvalid_i & awready_reg;
  assign w_take  = axi_wvalid_i & wready_reg;
  assign ar_take = axi_arvalid_i & arready_reg;
  assign wr_fire = aw_full_reg & w_full_reg & !bvalid_reg;
  assign aw_full_next = aw_take | (aw_full_reg & !wr_fire);
  assign w_full_next  = w_take | (w_full_reg & !wr_fire);
  assign rvalid_next  = ar_take | (rvalid_reg & !axi_rready_i);
  assign wr_stat = wr_fire && aw_addr_reg == `FDM_OFF_STATUS;
  assign wr_comm = wr_fire && aw_addr_reg == `FDM_OFF_COMM;
  assign wr_mask = wr_fire && aw_addr_reg == `FDM_OFF_IMASK;
  assign wr_rf   = wr_fire && aw_addr_reg[7:6] == `FDM_RF_PAGE;
  assign wr_ok   = aw_addr_reg == `FDM_OFF_STATUS
                || aw_addr_reg == `FDM_OFF_COMM
                || aw_addr_reg == `FDM_OFF_ISTAT
                || aw_addr_reg == `FDM_OFF_IMASK
                || aw_addr_reg[7:6] == `FDM_RF_PAGE;
  assign rd_istat = axi_araddr_i == `FDM_OFF_ISTAT;
  assign rd_ok = axi_araddr_i == `FDM_OFF_STATUS
              || axi_araddr_i == `FDM_OFF_COMM || rd_istat
              || axi_araddr_i == `FDM_OFF_IMASK
              || axi_araddr_i[7:6] == `FDM_RF_PAGE;
  assign rd_data = axi_araddr_i[7:6] == `FDM_RF_PAGE
                 ? rf[axi_araddr_i[5:2]]
                 : axi_araddr_i == `FDM_OFF_STATUS ? status_reg
                 : axi_araddr_i == `FDM_OFF_COMM ? comm_reg
                 : rd_istat ? istat_reg
                 : axi_araddr_i == `FDM_OFF_IMASK ? imask_reg : '0;

  // Write channels are taken in either order; the response follows both.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg} <= '0;
      {awready_reg, wready_reg, arready_reg} <= 3'h7;
      {bresp_reg, rresp_reg, aw_addr_reg, w_strb_reg} <= '0;
      {w_data_reg, rdata_reg} <= '0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= !aw_full_next;
      wready_reg  <= !w_full_next;
      bvalid_reg  <= wr_fire | (bvalid_reg & !axi_bready_i);
      rvalid_reg  <= rvalid_next;
      arready_reg <= !rvalid_next;
      if (aw_take) aw_addr_reg <= axi_awaddr_i;
      if (w_take) {w_data_reg, w_strb_reg} <= {axi_wdata_i, axi_wstrb_i};
      if (wr_fire) bresp_reg <= wr_ok ? `FDM_RESP_OK : `FDM_RESP_ERR;
      if (ar_take) rdata_reg <= rd_data;
      if (ar_take) rresp_reg <= rd_ok ? `FDM_RESP_OK : `FDM_RESP_ERR;
    end
  end

  // ----------------------------------------------------------------
  // Register file, status, communication and interrupt registers
  // ----------------------------------------------------------------
  // The core port wins over a bus write to the same word.
  for (genvar g = 0; g < 16; g++) begin : g_rf
    logic [31:0] q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) q <= '0;
      else if (core_we && core_wa == 4'(g)) q <= core_wd;
      else if (wr_rf && aw_addr_reg[5:2] == 4'(g))
        q <= wmerge(q, w_data_reg, w_strb_reg);
    end
    assign rf[g] = q;
  end

  logic [31:0] status_sw, status_next, istat_next, imask_next;
  logic [2:0]  ev;
  // Cause is replaced, beating a bus write; flags accumulate onto any bus-written flag value.
  assign status_sw = wr_stat ? (wmerge(status_reg, w_data_reg, w_strb_reg)
                     & `FDM_STATUS_WMSK) : status_reg;
  always_comb begin
    status_next = status_sw;
    if (cause_we) begin
      status_next[`FDM_CAUSE_LSB +: 6] = cause_n;
      status_next[`FDM_FLAG_LSB +: 5] = status_sw[`FDM_FLAG_LSB +: 5]
                                      | cause_n[4:0];
    end
  end
  // A read of the interrupt status clears it; an event in the same cycle still lands.
  assign ev = {undef_n, trap_n, done_n};
  assign istat_next = (ar_take && rd_istat ? '0 : istat_reg)
                    | {29'h0000_0000, ev};
  assign imask_next = wr_mask ? wmerge(imask_reg, w_data_reg, w_strb_reg)
                    : imask_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_reg <= `FDM_STATUS_RST;
      {comm_reg, istat_reg, imask_reg, lo_reg, lo_idx_reg} <= '0;
      state_reg <= fdm_pkg::fdm_idle;
      {done_reg, trap_reg, undef_reg, irq_reg} <= '0;
      ready_reg <= 1'h1;
    end else begin
      status_reg <= status_next;
      istat_reg  <= istat_next;
      imask_reg  <= imask_next;
      if (comm_we) comm_reg <= src_val;
      else if (wr_comm) comm_reg <= wmerge(comm_reg, w_data_reg, w_strb_reg);
      if (take) {lo_reg, lo_idx_reg} <= {dlo, n4[3:1], 1'h1};
      state_reg <= state_next;
      ready_reg <= state_next == fdm_pkg::fdm_idle;
      {undef_reg, trap_reg, done_reg} <= ev;
      irq_reg <= |(istat_next & imask_next);
    end
  end

  // Outputs straight from flip-flops.
  assign issue_ready_o = ready_reg;
  assign done_o  = done_reg;
  assign trap_o  = trap_reg;
  assign undef_o = undef_reg;
  assign axi_awready_o = awready_reg;
  assign axi_wready_o  = wready_reg;
  assign axi_bvalid_o  = bvalid_reg;
  assign axi_bresp_o   = bresp_reg;
  assign axi_arready_o = arready_reg;
  assign axi_rvalid_o  = rvalid_reg;
  assign axi_rdata_o   = rdata_reg;
  assign axi_rresp_o   = rresp_reg;
  assign irq_o         = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  load_zero_a: assert property (take && op_lz && !pr |=>
    rf[$past(n4)] == `FDM_ZERO_SP && done_o) else $error("zero load");
  load_one_a: assert property (take && op_lo && !pr |=>
    rf[$past(n4)] == `FDM_ONE_SP && done_o) else $error("one load");
  comm_move_a: assert property (take && op_mov |=>
    comm_reg == $past(src_val)) else $error("move to comm");
  cvt_two_a: assert property (take && op_cvt && pr && !en_i |=>
    !issue_ready_o && !done_o ##1 issue_ready_o && done_o)
    else $error("double convert timing");
  cvt_inexact_a: assert property (take && op_cvt && pr |=>
    !status_reg[`FDM_CAUSE_LSB]) else $error("double inexact");
  trap_always_a: assert property (take && (op_dot || op_mac) && !pr
    && en_oui |=> trap_o && rf[$past(ex_wa)] == $past(ex_old))
    else $error("trap enable");
  snan_inv_a: assert property (take && op_dot && !pr && |t_snan |=>
    status_reg[`FDM_CAUSE_LSB + 4] && status_reg[`FDM_FLAG_LSB + 4]
    && rf[$past(ex_wa)] == $past(ex_old)) else $error("snan invalid");
  undef_pr_a: assert property (take && (op_dot || op_mac) && pr |=>
    undef_o && !done_o && rf[$past(ex_wa)] == $past(ex_old))
    else $error("undefined op");
  dot_done_c: cover property (take && op_dot && !pr ##1 done_o && !trap_o);
  mac_done_c: cover property (take && op_mac && !pr ##1 done_o);
  cvt_dbl_c: cover property (take && op_cvt && pr ##2 done_o);
  irq_c: cover property (trap_o ##1 irq_o);
endmodule

/* dv/fdm_issue_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Issue side of the core feeding the unit
// ------------------------------------------------------------
module fdm_issue_model (
  // Clock and handshake.
  input  wire logic           clk_i,
  input  wire logic           ready_i,
  output fdm_pkg::fdm_issue_s issue_o
);
  // Nothing is offered until the bench asks.
  initial issue_o = '0;
  // Offer a code, hold it until taken, then idle so a two-state op ends.
  task automatic send(input logic [15:0] op);
    @(posedge clk_i);
    issue_o <= '{valid: 1'b1, opcode: op};
    do @(posedge clk_i); while (ready_i !== 1'b1);
    issue_o.valid <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

/* dv/fp_dot_load_convert_mac_tb.sv */
`timescale 1ns/1ps
module fp_dot_load_convert_mac_tb;
  logic        clk_i, nrst_i, awv, wv, bry, arv, rry;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [3:0]  ws, st;
  logic [1:0]  xr;
  wire         rdy, awr, wr, bv, arr, rv, irq, dn, tr, ud;
  wire [1:0]   br, rr;
  wire [31:0]  rdata;
  fdm_pkg::fdm_issue_s iss;
  int          n_fail = 0, check_count = 0, cyc = 0;
  int          n_dn = 0, n_tr = 0, n_ud = 0;
  fdm_unit uut (.clk_i(clk_i), .nrst_i(nrst_i), .issue_i(iss),
    .issue_ready_o(rdy), .done_o(dn), .trap_o(tr), .undef_o(ud),
    .axi_awvalid_i(awv), .axi_awaddr_i(awa), .axi_awready_o(awr),
    .axi_wvalid_i(wv), .axi_wdata_i(wd), .axi_wstrb_i(ws),
    .axi_wready_o(wr), .axi_bvalid_o(bv), .axi_bresp_o(br),
    .axi_bready_i(bry), .axi_arvalid_i(arv), .axi_araddr_i(ara),
    .axi_arready_o(arr), .axi_rvalid_o(rv), .axi_rdata_o(rdata),
    .axi_rresp_o(rr), .axi_rready_i(rry), .irq_o(irq));
  fdm_issue_model pm (.clk_i(clk_i), .ready_i(rdy), .issue_o(iss));
  // Clock, and a cycle ceiling well above the few hundred cycles needed.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Count the one-cycle outcome pulses so every one of them is judged.
  always @(posedge clk_i) begin
    cyc++;
    n_dn += dn;
    n_tr += tr;
    n_ud += ud;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus write: each channel is dropped on its own handshake.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ad, wdn;
    ad = 1'b0;
    wdn = 1'b0;
    @(posedge clk_i);
    {awv, wv, bry, awa, wd, ws} <= {3'b111, a, d, st};
    while (!(ad && wdn)) begin
      @(posedge clk_i);
      if (awv && awr) begin ad = 1'b1; awv <= 1'b0; end
      if (wv && wr) begin wdn = 1'b1; wv <= 1'b0; end
    end
    do @(posedge clk_i); while (bv !== 1'b1);
    bry <= 1'b0;
    chk({30'h0, br}, {30'h0, xr});
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk_i);
    {arv, rry, ara} <= {2'b11, a};
    do @(posedge clk_i); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk_i);
    rd = rdata;
    chk({30'h0, rr}, {30'h0, xr});
    rry <= 1'b0;
  endtask
  task automatic t_loads();
    axw(8'h54, 32'h1234_5678);
    pm.send(16'hF58D); axr(8'h54); chk(rd, 32'h0000_0000);
    pm.send(16'hF59D); axr(8'h54); chk(rd, 32'h3F80_0000);
    pm.send(16'hF51D); axr(8'h04); chk(rd, 32'h3F80_0000);
    axw(8'h04, 32'hFFFF_FFFD);
    pm.send(16'hF62D); axr(8'h58); chk(rd, 32'hC040_0000);
    // Only the two low byte lanes may land.
    st = 4'h3;
    axw(8'h54, 32'hAAAA_BBBB);
    st = 4'hF;
    axr(8'h54); chk(rd, 32'h3F80_BBBB);
    // An unmapped word answers with an error and reads as zero.
    xr = 2'h2;
    axw(8'h10, 32'h0000_0001);
    axr(8'h10); chk(rd, 32'h0000_0000);
    xr = 2'h0;
  endtask
  task automatic t_dot();
    for (int i = 0; i < 4; i++) begin
      pm.send(16'hF09D | 16'(i << 8));
      axw(8'h50 + 8'(4 * i), 32'h4000_0000);
    end
    pm.send(16'hF4ED); axr(8'h5C); chk(rd, 32'h4100_0000);
    axw(8'h50, 32'h7F80_0000);
    axw(8'h40, 32'h0000_0000);
    pm.send(16'hF4ED); axr(8'h5C); chk(rd, 32'h4100_0000);
    axr(8'h00); chk(rd, 32'h0001_0040);
  endtask
  task automatic t_trap();
    axw(8'h00, 32'h0000_0080);
    axw(8'h50, 32'h4000_0000);
    axw(8'h5C, 32'h0000_0000);
    pm.send(16'hF4ED); axr(8'h5C); chk(rd, 32'h0000_0000);
    axr(8'h08); chk(rd & 32'h2, 32'h0000_0002);
  endtask
  task automatic t_prec();
    axw(8'h00, 32'h0008_0000);
    axw(8'h0C, 32'h0000_0004);
    pm.send(16'hF4ED); axr(8'h5C); chk(rd, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0001);
    axr(8'h08); chk(rd & 32'h4, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0000_0000);
    axw(8'h04, 32'h0000_0005);
    pm.send(16'hF22D); axr(8'h48); chk(rd, 32'h4014_0000);
    axr(8'h4C); chk(rd, 32'h0000_0000);
  endtask
  // Multiply-accumulate, denormal flush and a lossy single convert.
  task automatic t_mac();
    axw(8'h00, 32'h0000_0000);
    axw(8'h40, 32'h4000_0000);
    axw(8'h44, 32'h4040_0000);
    axw(8'h48, 32'h3F80_0000);
    pm.send(16'hF21E); axr(8'h48); chk(rd, 32'h40E0_0000);
    axw(8'h00, 32'h0004_0000);
    axw(8'h44, 32'h0000_0001);
    pm.send(16'hF21E); axr(8'h00); chk(rd, 32'h0004_0000);
    axw(8'h04, 32'h0100_0001);
    pm.send(16'hF32D); axr(8'h00); chk(rd, 32'h0004_1004);
    chk(n_dn, 32'h0000_000F);
    chk(n_tr, 32'h0000_0001);
    chk(n_ud, 32'h0000_0001);
  endtask
  // Reset for four cycles with every input at rest, then the scenarios.
  initial begin
    {nrst_i, awv, wv, bry, arv, rry, awa, ara, wd, ws, xr} = '0;
    st = 4'hF;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_loads();
    t_dot();
    t_trap();
    t_prec();
    t_mac();
    wrap_up();
  end
endmodule
